// >>> rtl/cra_ctrl.sv
// counter ramp converter control: counter, source select, convert gating latch
`timescale 1ns/1ps
// Function
// RL1 - counter steps on each falling clock edge
// RL2 - low reset clears counter, holds counting
// RL3 - select low external code, high counter
// RL4 - counter value driven onto data terminals
// RL5 - unsigned 8-bit code, output n/256 reference
// RL6 - convert pulse clears counter, sets latch
// RL7 - latch set passes clock to counter
// RL8 - comparator trip stops clocks, holds count
// RL9 - conversion clock kept at most 400 kHz
// RL10 - conversion time equals counts times period
// RL11 - continuous convert pulses repeat conversions
// RL12 - counter wraps from all ones to zero
// RL13 - comparator passes two flip-flops first
// RL14 - done flag raised until next convert
module cra_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cnt_clk,
  input wire logic i_cnt_rst_n,
  input wire logic i_src_sel,
  input wire logic [7:0] i_ext_code,
  input wire logic i_convert,
  input wire logic i_cmp,
  output cra_pkg::cra_ladder_t o_ladder,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_gate,
  output logic o_done
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic clk_fall;
  logic cnt_rst_lvl;
  logic src_lvl;
  logic conv_lvl;
  logic conv_rise;
  logic cmp_lvl;
  logic cmp_fall;
  logic [7:0] ext_s1_q;
  logic [7:0] ext_s2_q;

  cra_sync u_clk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_cnt_clk),
    .o_level(), .o_fall(clk_fall), .o_rise());
  cra_sync u_crst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_cnt_rst_n),
    .o_level(cnt_rst_lvl), .o_fall(), .o_rise());
  cra_sync u_sel (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_src_sel),
    .o_level(src_lvl), .o_fall(), .o_rise());
  cra_sync u_conv (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_convert),
    .o_level(conv_lvl), .o_fall(), .o_rise(conv_rise));
  // comparator settled through two flops before gating logic
  cra_sync u_cmp (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_cmp), // RL13
    .o_level(cmp_lvl), .o_fall(cmp_fall), .o_rise());

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ext_s1_q <= cra_pkg::CODE_RESET;
      ext_s2_q <= cra_pkg::CODE_RESET;
    end else begin
      ext_s1_q <= i_ext_code;
      ext_s2_q <= ext_s1_q;
    end
  end

  // ----------------------------------------
  // gating latch state machine
  // ----------------------------------------
  cra_pkg::cra_state_t state_q;
  cra_pkg::cra_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic done_q;
  logic done_d;
  logic gate_on;
  logic step;

  assign gate_on = (state_q == cra_pkg::CRA_RUN);
  // free ramp when idle, gated clock during conversion
  assign step = clk_fall & cnt_rst_lvl & ((state_q == cra_pkg::CRA_IDLE) | gate_on); // RL7

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cra_pkg::CRA_IDLE: if (conv_rise) state_d = cra_pkg::CRA_CLEAR; // RL6
      cra_pkg::CRA_CLEAR: if (!conv_lvl) state_d = cra_pkg::CRA_RUN;
      cra_pkg::CRA_RUN: begin
        if (conv_rise) begin
          state_d = cra_pkg::CRA_CLEAR; // RL11
        end else if (cmp_fall) begin
          state_d = cra_pkg::CRA_DONE; // RL8
        end
      end
      cra_pkg::CRA_DONE: if (conv_rise) state_d = cra_pkg::CRA_CLEAR; // RL11
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    if (!cnt_rst_lvl) begin
      cnt_d = cra_pkg::CODE_RESET; // RL2
    end else if (state_d == cra_pkg::CRA_CLEAR) begin
      cnt_d = cra_pkg::CODE_RESET; // RL6
    end else if (step && !(gate_on && cmp_fall)) begin
      // 8-bit add wraps from all ones to zero
      cnt_d = cnt_q + 8'h01; // RL1 RL12 RL10
    end
  end

  assign done_d = (state_d == cra_pkg::CRA_DONE); // RL14

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= cra_pkg::CRA_IDLE;
      cnt_q <= cra_pkg::CODE_RESET;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------
  // ladder source select and data terminals
  // ----------------------------------------
  logic [7:0] code_mux;
  logic [7:0] ladder_code_q;
  logic sel_q;
  assign code_mux = src_lvl ? cnt_q : ext_s2_q; // RL3 RL5

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ladder_code_q <= cra_pkg::CODE_RESET;
      sel_q <= 1'b0;
    end else begin
      ladder_code_q <= code_mux;
      sel_q <= src_lvl;
    end
  end

  assign o_ladder.code = ladder_code_q;
  assign o_ladder.from_counter = sel_q;
  assign o_data = ladder_code_q; // RL4
  assign o_data_oe = sel_q; // RL4
  assign o_gate = gate_on;
  assign o_done = done_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_trip;
    gate_on && cmp_fall && !conv_rise;
  endsequence

  property p_count_step;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (step && cnt_rst_lvl && state_d != cra_pkg::CRA_CLEAR && !(gate_on && cmp_fall))
      |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step"); // RL1

  property p_reset_clear;
    @(posedge i_mclk) disable iff (!i_rst_n) !cnt_rst_lvl |=> cnt_q == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("counter not cleared"); // RL2

  property p_select;
    @(posedge i_mclk) disable iff (!i_rst_n)
      ##1 ladder_code_q == ($past(src_lvl) ? $past(cnt_q) : $past(ext_s2_q));
  endproperty
  a_select: assert property (p_select) else $error("wrong ladder source"); // RL3

  property p_data_out;
    @(posedge i_mclk) disable iff (!i_rst_n) o_data_oe |-> o_data == $past(cnt_q);
  endproperty
  a_data_out: assert property (p_data_out) else $error("data terminals wrong"); // RL4

  property p_convert_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
      conv_rise && cnt_rst_lvl |=> cnt_q == 8'h00 && state_q == cra_pkg::CRA_CLEAR;
  endproperty
  a_convert_clear: assert property (p_convert_clear) else $error("convert did not clear"); // RL6

  property p_gate_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (state_q == cra_pkg::CRA_DONE && !conv_rise && cnt_rst_lvl) |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved after trip"); // RL8

  property p_trip;
    @(posedge i_mclk) disable iff (!i_rst_n) s_trip |=> !gate_on ##0 o_done;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not stop"); // RL8

  property p_wrap;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (cnt_q == 8'hff && step && cnt_rst_lvl && state_d != cra_pkg::CRA_CLEAR && !(gate_on && cmp_fall))
      |=> cnt_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // RL12

  property p_done_hold;
    @(posedge i_mclk) disable iff (!i_rst_n) o_done && !conv_rise |=> o_done;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped early"); // RL14

  // pin edge reaches the gating logic two clocks late
  property p_cmp_use;
    @(posedge i_mclk) disable iff (!i_rst_n)
      cmp_fall |-> !$past(i_cmp, 2) && $past(i_cmp, 3);
  endproperty
  a_cmp_use: assert property (p_cmp_use) else $error("comparator edge bad"); // RL13

  sequence s_restart;
    gate_on && conv_rise;
  endsequence

  property p_restart;
    @(posedge i_mclk) disable iff (!i_rst_n)
      s_restart |=> state_q == cra_pkg::CRA_CLEAR && !o_done && cnt_q == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("convert did not restart"); // RL11

  property p_clear_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
      state_q == cra_pkg::CRA_CLEAR |-> cnt_q == 8'h00 && !o_gate;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("counter moved while clearing"); // RL6
endmodule

// >>> rtl/cra_pkg.sv
// package: constants and carrier types for the counter ramp converter control
package cra_pkg;
  localparam int CODE_W = 8;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] CODE_FULL = 8'hff;
  localparam int CLK_MHZ = 100;
  // least convert pulse width in microseconds
  localparam int CONV_MIN_US = 15;
  localparam int CONV_MIN_CYC = CONV_MIN_US * CLK_MHZ;
  // shortest conversion clock period in nanoseconds (400 kHz)
  localparam int CONV_CLK_MIN_NS = 2500;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {
    CRA_IDLE = 2'b00,
    CRA_CLEAR = 2'b01,
    CRA_RUN = 2'b10,
    CRA_DONE = 2'b11
  } cra_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic from_counter;
  } cra_ladder_t;
endpackage

// >>> rtl/cra_sync.sv
// two flip-flop synchroniser with falling edge detect on the settled level
`timescale 1ns/1ps
module cra_sync (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_fall,
  output logic o_rise
);
  logic [1:0] sync_q;
  logic last_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sync_q <= cra_pkg::SYNC_RESET;
      last_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], i_async};
      last_q <= sync_q[1];
    end
  end

  assign o_level = sync_q[1];
  assign o_fall = last_q & ~sync_q[1];
  assign o_rise = ~last_q & sync_q[1];
endmodule

// >>> bench/cra_partner.sv
// comparator and conversion clock source model
`timescale 1ns/1ps
module cra_partner (
  input wire logic i_run,
  input wire logic i_fast,
  input wire logic [7:0] i_code,
  input wire logic [7:0] i_level,
  output logic o_cnt_clk,
  output logic o_cmp
);
  // --------------------------------
  // comparator: high while ramp below level
  // --------------------------------
  assign o_cmp = (i_code < i_level);
  // clock idles high between frames; fast only for free ramp mode
  initial begin
    o_cnt_clk = 1'b1;
    forever begin
      if (i_run) begin
        #(i_fast ? 100 : 1250) o_cnt_clk = 1'b0;
        #(i_fast ? 100 : 1250) o_cnt_clk = 1'b1;
      end else begin
        @(i_run);
      end
    end
  end
endmodule

// >>> bench/cra_ctrl_tb_top.sv
// testbench for the counter ramp converter control
`timescale 1ns/1ps
module cra_ctrl_tb_top;
  logic i_mclk, i_rst_n, cnt_rst_n, src_sel, convert, run, fast, cnt_clk, cmp, data_oe, gate, done;
  logic [7:0] ext_code, level, data;
  cra_pkg::cra_ladder_t ladder;
  int num_errors, checks, exp_cnt, mode, seed, t, i;
  cra_ctrl i_cra_ctrl (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cnt_clk(cnt_clk), .i_cnt_rst_n(cnt_rst_n),
    .i_src_sel(src_sel), .i_ext_code(ext_code), .i_convert(convert), .i_cmp(cmp), .o_ladder(ladder),
    .o_data(data), .o_data_oe(data_oe), .o_gate(gate), .o_done(done));
  cra_partner i_cra_partner (.i_run(run), .i_fast(fast), .i_code(ladder.code), .i_level(level),
    .o_cnt_clk(cnt_clk), .o_cmp(cmp));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // --------------------------------
  // reference counter model
  // --------------------------------
  always @(negedge cnt_clk) begin
    if (mode == 0 && cnt_rst_n) exp_cnt = (exp_cnt + 1) % 256;
    if (mode == 2 && exp_cnt < level) exp_cnt = exp_cnt + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_code(input logic [7:0] got, input int want);
    checks++;
    if (got !== want[7:0]) begin
      num_errors++;
      $display("mismatch at %0t: code %h want %h", $time, got, want[7:0]);
    end
  endtask
  task automatic chk_bit(input logic got, input logic want);
    checks++;
    if (got !== want) begin
      num_errors++;
      $display("mismatch at %0t: flag %b want %b", $time, got, want);
    end
  endtask
  task automatic convert_once(input logic [7:0] lvl);
    level = lvl;
    convert = 1'b1;
    mode = 1;
    exp_cnt = 0;
    tick(cra_pkg::CONV_MIN_CYC);
    chk_code(data, 0);
    chk_bit(done, 1'b0);
    convert = 1'b0;
    tick(10);
    chk_bit(gate, 1'b1);
    mode = 2;
    run = 1'b1;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      tick(1);
      t++;
    end
    run = 1'b0;
    if (t >= 3000) begin
      num_errors++;
      $display("mismatch at %0t: conversion never finished", $time);
      give_verdict();
    end
    chk_bit(t >= 250 * lvl - 125 && t <= 250 * lvl - 105, 1'b1);
    chk_code(ladder.code, exp_cnt);
    chk_bit(gate, 1'b0);
    tick(300);
    chk_code(data, lvl);
    chk_bit(done, 1'b1);
  endtask
  initial begin
    i_rst_n = 1'b0;
    cnt_rst_n = 1'b1;
    src_sel = 1'b1;
    ext_code = 8'h00;
    convert = 1'b0;
    run = 1'b0;
    fast = 1'b1;
    level = 8'h00;
    seed = 32'h19b5;
    num_errors = 0;
    checks = 0;
    exp_cnt = 0;
    mode = 0;
    tick(5);
    chk_bit(gate, 1'b0);
    chk_bit(done, 1'b0);
    i_rst_n = 1'b1;
    cnt_rst_n = 1'b0;
    run = 1'b1;
    tick(105);
    chk_code(data, 0);
    cnt_rst_n = 1'b1;
    tick(5200);
    run = 1'b0;
    tick(120);
    chk_code(data, exp_cnt);
    chk_bit(data_oe, 1'b1);
    chk_bit(ladder.from_counter, 1'b1);
    cnt_rst_n = 1'b0;
    exp_cnt = 0;
    tick(10);
    chk_code(data, 0);
    cnt_rst_n = 1'b1;
    for (i = 0; i < 3; i++) begin
      src_sel = 1'b0;
      ext_code = 8'($random(seed));
      tick(10);
      chk_code(ladder.code, ext_code);
      chk_bit(ladder.from_counter, 1'b0);
      chk_bit(data_oe, 1'b0);
    end
    src_sel = 1'b1;
    fast = 1'b0;
    tick(10);
    // convert arriving mid ramp restarts from zero
    level = 8'hf0;
    convert = 1'b1;
    tick(cra_pkg::CONV_MIN_CYC);
    convert = 1'b0;
    mode = 2;
    exp_cnt = 0;
    tick(10);
    run = 1'b1;
    tick(1100);
    run = 1'b0;
    tick(300);
    chk_code(data, exp_cnt);
    chk_bit(gate, 1'b1);
    convert = 1'b1;
    tick(10);
    chk_code(data, 0);
    chk_bit(gate, 1'b0);
    tick(cra_pkg::CONV_MIN_CYC);
    convert = 1'b0;
    tick(10);
    chk_bit(gate, 1'b1);
    // back to back conversions
    for (i = 0; i < 4; i++) convert_once(8'($unsigned($random(seed)) % 6 + 1));
    give_verdict();
  end
endmodule
